// ---- rtl/io_memory_map_decoder.sv ----
`timescale 1ns/10ps
module io_memory_map_decoder
  import io_map_pkg::*;
#(
  parameter bit DISP_IN_PAGE2 = 1'b0
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // CPU data memory access
  input wire logic MEM_RD_I,
  input wire logic MEM_WR_I,
  input wire logic [11:0] MEM_ADDR_I,
  input wire logic [3:0] MEM_WDATA_I,
  output logic [3:0] MEM_RDATA_O,
  output logic MEM_HIT_O,
  // Peripheral state in
  input wire logic [3:0] CLK_TAPS_I,
  input wire logic [3:0] SW_HUNDREDTHS_I,
  input wire logic [3:0] SW_TENTHS_I,
  input wire logic [3:0] IN_PIN_I,
  input wire logic SUB_BATTERY_DETECT_I,
  // Control out
  output logic LCD_BLANK_CTL_O,
  output logic [3:0] IN_CMP_O,
  output logic [3:0] IN_IRQ_EN_O,
  output logic HEAVY_LOAD_SEL_O,
  output logic SWATCH_1HZ_IRQ_EN_O,
  output logic SWATCH_10HZ_IRQ_EN_O,
  // Display memory to LCD driver
  input wire logic [5:0] DISP_RADDR_I,
  output logic [3:0] DISP_RDATA_O
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic batt_meta_reg;
  logic batt_sync_reg;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= NIBBLE_ZERO;
      pin_sync_reg <= NIBBLE_ZERO;
      batt_meta_reg <= 1'b0;
      batt_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= IN_PIN_I;
      pin_sync_reg <= pin_meta_reg;
      batt_meta_reg <= SUB_BATTERY_DETECT_I;
      batt_sync_reg <= batt_meta_reg;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  mem_req_type req;
  logic [11:0] disp_base;
  logic disp_hit;
  logic [5:0] disp_idx;
  logic ram_hit;
  logic [9:0] ram_idx;
  logic io_hit;

  assign req = '{rd: MEM_RD_I, wr: MEM_WR_I, addr: MEM_ADDR_I, wdata: MEM_WDATA_I};
  assign disp_base = DISP_IN_PAGE2 ? DISP_BASE_PAGE2 : DISP_BASE_PAGE0; // [RQ3]

  function automatic logic in_range(input logic [11:0] a, input logic [11:0] base, input int words);
    in_range = (a >= base) && (int'(a) < int'(base) + words);
  endfunction

  function automatic logic is_io(input logic [11:0] a);
    is_io = (a == ADDR_LCD_BLANK) || ((a >= ADDR_CLK_TAPS) && (a <= ADDR_LOAD_MODE));
  endfunction

  // RAM skips the page 2 display and I/O area
  function automatic logic is_ram(input logic [11:0] a);
    is_ram = (a <= RAM_TOP) && !((a >= RAM_HOLE_FIRST) && (a <= RAM_HOLE_LAST));
  endfunction

  // Closes the hole so storage stays dense
  function automatic logic [9:0] ram_index(input logic [11:0] a);
    if (a > RAM_HOLE_LAST) begin
      ram_index = 10'(a - RAM_HOLE_WORDS);
    end else begin
      ram_index = a[9:0];
    end
  endfunction

  always_comb begin
    disp_hit = in_range(req.addr, disp_base, DISP_WORDS); // [RQ3]
    disp_idx = 6'(req.addr - disp_base);
    ram_hit = is_ram(req.addr); // [RQ2]
    ram_idx = ram_index(req.addr);
    io_hit = is_io(req.addr); // [RQ1]
  end

  // ----------------------------------------
  // Display memory
  // ----------------------------------------
  logic disp_wr;
  logic [5:0] disp_raddr;
  logic [3:0] disp_q;

  assign disp_wr = req.wr && disp_hit;
  assign disp_raddr = (req.rd && disp_hit) ? disp_idx : DISP_RADDR_I;

  nibble_store #(
    .DEPTH(DISP_WORDS),
    .AW(6)
  ) u_disp (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .wr_i(disp_wr),
    .waddr_i(disp_idx),
    .wdata_i(req.wdata),
    .raddr_i(disp_raddr),
    .rdata_o(disp_q)
  );

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      DISP_RDATA_O <= NIBBLE_ZERO;
    end else begin
      DISP_RDATA_O <= disp_q;
    end
  end

  // ----------------------------------------
  // General RAM outside display window
  // ----------------------------------------
  logic ram_wr;
  logic [3:0] ram_q;

  assign ram_wr = req.wr && ram_hit && !(disp_hit && !DISP_IN_PAGE2);

  nibble_store #(
    .DEPTH(RAM_WORDS),
    .AW(10)
  ) u_ram (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .wr_i(ram_wr),
    .waddr_i(ram_idx),
    .wdata_i(req.wdata),
    .raddr_i(ram_idx),
    .rdata_o(ram_q)
  );

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  ctrl_type ctrl_reg;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg.lcd_blank_ctl <= LCD_BLANK_RESET[LCD_BLANK_BIT];
      ctrl_reg.in_cmp <= NIBBLE_RESET; // [RQ11]
      ctrl_reg.in_irq_en <= NIBBLE_RESET; // [RQ12]
      ctrl_reg.heavy_load_sel <= 1'b0; // [RQ13]
      ctrl_reg.swatch_1hz_irq_en <= 1'b0; // [RQ14]
      ctrl_reg.swatch_10hz_irq_en <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == ADDR_LCD_BLANK) begin
        ctrl_reg.lcd_blank_ctl <= req.wdata[LCD_BLANK_BIT]; // [RQ15]
      end else if (req.addr == ADDR_IN_CMP) begin
        ctrl_reg.in_cmp <= req.wdata; // [RQ11]
      end else if (req.addr == ADDR_IN_IRQ_EN) begin
        ctrl_reg.in_irq_en <= req.wdata; // [RQ12]
      end else if (req.addr == ADDR_LOAD_MODE) begin
        ctrl_reg.heavy_load_sel <= req.wdata[HEAVY_LOAD_BIT]; // [RQ13]
        ctrl_reg.swatch_1hz_irq_en <= req.wdata[SW1HZ_EN_BIT]; // [RQ14]
        ctrl_reg.swatch_10hz_irq_en <= req.wdata[SW10HZ_EN_BIT];
      end
    end
  end

  assign LCD_BLANK_CTL_O = ctrl_reg.lcd_blank_ctl;
  assign IN_CMP_O = ctrl_reg.in_cmp;
  assign IN_IRQ_EN_O = ctrl_reg.in_irq_en;
  assign HEAVY_LOAD_SEL_O = ctrl_reg.heavy_load_sel;
  assign SWATCH_1HZ_IRQ_EN_O = ctrl_reg.swatch_1hz_irq_en;
  assign SWATCH_10HZ_IRQ_EN_O = ctrl_reg.swatch_10hz_irq_en;

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  timer_view_type tview;
  logic [3:0] rdata_next;
  logic hit_next;
  logic [3:0] rdata_reg;
  logic hit_reg;

  assign tview = '{clk_taps: CLK_TAPS_I, sw_hundredths: SW_HUNDREDTHS_I, sw_tenths: SW_TENTHS_I};

  always_comb begin
    rdata_next = NIBBLE_ZERO;
    hit_next = 1'b0;
    if (req.addr == ADDR_LCD_BLANK) begin
      rdata_next[LCD_BLANK_BIT] = ctrl_reg.lcd_blank_ctl; // [RQ15]
      hit_next = 1'b1;
    end else if (req.addr == ADDR_CLK_TAPS) begin
      rdata_next = tview.clk_taps; // [RQ7]
      hit_next = 1'b1;
    end else if (req.addr == ADDR_SW_HUND) begin
      rdata_next = tview.sw_hundredths; // [RQ8]
      hit_next = 1'b1;
    end else if (req.addr == ADDR_SW_TENTH) begin
      rdata_next = tview.sw_tenths; // [RQ9]
      hit_next = 1'b1;
    end else if (req.addr == ADDR_IN_LEVELS) begin
      rdata_next = pin_sync_reg; // [RQ10]
      hit_next = 1'b1;
    end else if (req.addr == ADDR_IN_CMP) begin
      rdata_next = ctrl_reg.in_cmp;
      hit_next = 1'b1;
    end else if (req.addr == ADDR_IN_IRQ_EN) begin
      rdata_next = ctrl_reg.in_irq_en;
      hit_next = 1'b1;
    end else if (req.addr == ADDR_LOAD_MODE) begin
      rdata_next = {ctrl_reg.heavy_load_sel, batt_sync_reg, ctrl_reg.swatch_1hz_irq_en,
                    ctrl_reg.swatch_10hz_irq_en};
      hit_next = 1'b1;
    end else if (disp_hit && DISP_IN_PAGE2) begin
      rdata_next = NIBBLE_ZERO; // [RQ5]
      hit_next = 1'b1;
    end else if (disp_hit) begin
      rdata_next = disp_q; // [RQ4]
      hit_next = 1'b1;
    end else if (ram_hit) begin
      rdata_next = ram_q;
      hit_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= NIBBLE_ZERO;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= req.rd ? rdata_next : NIBBLE_ZERO;
      hit_reg <= req.rd && hit_next; // [RQ6]
    end
  end

  assign MEM_RDATA_O = rdata_reg;
  assign MEM_HIT_O = hit_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  a_cmp_write: assert property (req.wr && req.addr == ADDR_IN_CMP |=> IN_CMP_O == $past(req.wdata)) // [RQ11]
    else $error("compare register write lost");
  a_en_write: assert property (req.wr && req.addr == ADDR_IN_IRQ_EN |=> IN_IRQ_EN_O == $past(req.wdata)) // [RQ12]
    else $error("irq enable write lost");
  a_heavy_load: assert property (req.wr && req.addr == ADDR_LOAD_MODE |=> // [RQ13]
    HEAVY_LOAD_SEL_O == $past(req.wdata[HEAVY_LOAD_BIT])) else $error("heavy load bit wrong");
  a_sw_irq_en: assert property (req.wr && req.addr == ADDR_LOAD_MODE |=> // [RQ14]
    SWATCH_1HZ_IRQ_EN_O == $past(req.wdata[SW1HZ_EN_BIT])) else $error("stopwatch enable wrong");
  a_taps_read: assert property (req.rd && req.addr == ADDR_CLK_TAPS |=> // [RQ7]
    MEM_RDATA_O == $past(CLK_TAPS_I) && MEM_HIT_O) else $error("tap read wrong");
  a_hund_read: assert property (req.rd && req.addr == ADDR_SW_HUND |=> // [RQ8]
    MEM_RDATA_O == $past(SW_HUNDREDTHS_I)) else $error("hundredths read wrong");
  a_tenth_read: assert property (req.rd && req.addr == ADDR_SW_TENTH |=> // [RQ9]
    MEM_RDATA_O == $past(SW_TENTHS_I)) else $error("tenths read wrong");
  a_pin_read: assert property (req.rd && req.addr == ADDR_IN_LEVELS |=> // [RQ10]
    MEM_RDATA_O == $past(IN_PIN_I, 3)) else $error("pin level read wrong");
  a_lcd_unused: assert property (req.rd && req.addr == ADDR_LCD_BLANK |=> // [RQ15]
    MEM_RDATA_O[3:1] == 3'h0) else $error("unused bits not zero");
  a_disp_wonly: assert property (DISP_IN_PAGE2 && req.rd && disp_hit |=> // [RQ5]
    MEM_RDATA_O == NIBBLE_ZERO) else $error("page 2 display readable");
  a_disp_rw: assert property (!DISP_IN_PAGE2 && req.wr && disp_hit ##1 req.rd && // [RQ4]
    req.addr == $past(req.addr) |=> MEM_RDATA_O == $past(req.wdata, 2)) else $error("display readback wrong");

  c_cmp_write: cover property (req.wr && req.addr == ADDR_IN_CMP);
  c_disp_write: cover property (req.wr && disp_hit);
  c_unmapped_rd: cover property (req.rd && !hit_next);
  c_p2_disp_rd: cover property (DISP_IN_PAGE2 && req.rd && disp_hit);
  c_pin_read: cover property (req.rd && req.addr == ADDR_IN_LEVELS);

  // ----------------------------------------
  // Decode, readback and write checks
  // ----------------------------------------
  a_io_hit: assert property (req.rd && io_hit |=> // [RQ1]
    MEM_HIT_O)
    else $error("register read not decoded");
  a_idle_zero: assert property (!req.rd |=> // [RQ1]
    MEM_RDATA_O == NIBBLE_ZERO && !MEM_HIT_O)
    else $error("read data without a read");
  a_hole_rd: assert property (req.rd && !is_ram(req.addr) && !io_hit && !disp_hit |=> // [RQ2]
    !MEM_HIT_O && MEM_RDATA_O == NIBBLE_ZERO)
    else $error("unmapped read answered");
  a_ram_rw: assert property (ram_wr ##1 req.rd && req.addr == $past(req.addr) |=> // [RQ2]
    MEM_RDATA_O == $past(req.wdata, 2))
    else $error("RAM readback wrong");
  a_page0_hole: assert property (!DISP_IN_PAGE2 && req.rd && // [RQ3]
    in_range(req.addr, DISP_BASE_PAGE2, DISP_WORDS) |=> !MEM_HIT_O)
    else $error("page 2 display area decoded in page 0 build");
  a_p2_hit: assert property (DISP_IN_PAGE2 && req.rd && disp_hit |=> // [RQ5]
    MEM_HIT_O)
    else $error("page 2 display read not decoded");
  a_cmp_read: assert property (req.rd && req.addr == ADDR_IN_CMP |=> // [RQ11]
    MEM_RDATA_O == $past(IN_CMP_O))
    else $error("compare register read wrong");
  a_en_read: assert property (req.rd && req.addr == ADDR_IN_IRQ_EN |=> // [RQ12]
    MEM_RDATA_O == $past(IN_IRQ_EN_O))
    else $error("irq enable read wrong");
  a_load_read: assert property (req.rd && req.addr == ADDR_LOAD_MODE |=> // [RQ13]
    MEM_RDATA_O[HEAVY_LOAD_BIT] == $past(HEAVY_LOAD_SEL_O))
    else $error("heavy load read wrong");
  a_sw1_read: assert property (req.rd && req.addr == ADDR_LOAD_MODE |=> // [RQ14]
    MEM_RDATA_O[SW1HZ_EN_BIT] == $past(SWATCH_1HZ_IRQ_EN_O))
    else $error("stopwatch enable read wrong");
  a_en10_write: assert property (req.wr && req.addr == ADDR_LOAD_MODE |=> // [RQ1]
    SWATCH_10HZ_IRQ_EN_O == $past(req.wdata[SW10HZ_EN_BIT]))
    else $error("10 Hz enable write lost");
  a_batt_read: assert property (req.rd && req.addr == ADDR_LOAD_MODE |=> // [RQ15]
    MEM_RDATA_O[SUB_BATT_BIT] == $past(SUB_BATTERY_DETECT_I, 3))
    else $error("sub-battery bit wrong");
  a_lcd_write: assert property (req.wr && req.addr == ADDR_LCD_BLANK |=> // [RQ15]
    LCD_BLANK_CTL_O == $past(req.wdata[LCD_BLANK_BIT]))
    else $error("display blank write lost");
  a_lcd_read: assert property (req.rd && req.addr == ADDR_LCD_BLANK |=> // [RQ15]
    MEM_RDATA_O[LCD_BLANK_BIT] == $past(LCD_BLANK_CTL_O))
    else $error("display blank read wrong");
  a_ro_write: assert property (req.wr && req.addr >= ADDR_CLK_TAPS && req.addr <= ADDR_IN_LEVELS |=> // [RQ15]
    $stable(ctrl_reg))
    else $error("read-only write changed a register");
endmodule

// ---- rtl/io_map_pkg.sv ----
// Operation
// [RQ1] Peripherals appear as data-memory nibbles
// [RQ2] 865 or 913 words; 48 display, 33 I/O
// [RQ3] Build option places display page 0 or 2
// [RQ4] Page 0 display memory is read/write
// [RQ5] Page 2 display memory is write-only
// [RQ6] Program avoids unused and unmapped addresses
// [RQ7] 2E0H reads clock divider taps 2..16 Hz
// [RQ8] 2E1H reads stopwatch hundredths BCD digit
// [RQ9] 2E2H reads stopwatch tenths BCD digit
// [RQ10] 2E3H reads live input pin levels
// [RQ11] 2E4H holds per-pin edge comparison bits
// [RQ12] 2E5H holds per-pin interrupt enables
// [RQ13] LOAD_MODE_AND_SWATCH_IRQ_ENABLE bit 3 selects heavy-load mode
// [RQ14] LOAD_MODE_AND_SWATCH_IRQ_ENABLE bit 1 enables stopwatch 1 Hz irq
// [RQ15] Unused bits read zero; read-only writes ignored
package io_map_pkg;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [11:0] ADDR_LCD_BLANK = 12'h02d0;
  localparam logic [11:0] ADDR_CLK_TAPS = 12'h02e0;
  localparam logic [11:0] ADDR_SW_HUND = 12'h02e1;
  localparam logic [11:0] ADDR_SW_TENTH = 12'h02e2;
  localparam logic [11:0] ADDR_IN_LEVELS = 12'h02e3;
  localparam logic [11:0] ADDR_IN_CMP = 12'h02e4;
  localparam logic [11:0] ADDR_IN_IRQ_EN = 12'h02e5;
  localparam logic [11:0] ADDR_LOAD_MODE = 12'h02e6;
  localparam logic [11:0] DISP_BASE_PAGE0 = 12'h0040;
  localparam logic [11:0] DISP_BASE_PAGE2 = 12'h0240;
  localparam int DISP_WORDS = 48;
  localparam int RAM_WORDS = 832;
  localparam int IO_WORDS = 33;
  localparam int SPACE_WORDS_PAGE0 = 865;
  localparam int SPACE_WORDS_PAGE2 = 913;
  localparam logic [11:0] RAM_HOLE_FIRST = 12'h0240;
  localparam logic [11:0] RAM_HOLE_LAST = 12'h02ff;
  localparam logic [11:0] RAM_HOLE_WORDS = 12'h00c0;
  localparam logic [11:0] RAM_TOP = 12'h03ff;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int LCD_BLANK_BIT = 0;
  localparam int HEAVY_LOAD_BIT = 3;
  localparam int SUB_BATT_BIT = 2;
  localparam int SW1HZ_EN_BIT = 1;
  localparam int SW10HZ_EN_BIT = 0;
  localparam logic [3:0] LCD_BLANK_RESET = 4'h1;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] BCD_MAX = 4'h9;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic [3:0] clk_taps;
    logic [3:0] sw_hundredths;
    logic [3:0] sw_tenths;
  } timer_view_type;

  typedef struct packed {
    logic lcd_blank_ctl;
    logic [3:0] in_cmp;
    logic [3:0] in_irq_en;
    logic heavy_load_sel;
    logic swatch_1hz_irq_en;
    logic swatch_10hz_irq_en;
  } ctrl_type;
endpackage

// ---- rtl/nibble_store.sv ----
`timescale 1ns/10ps
module nibble_store
  import io_map_pkg::*;
#(
  parameter int DEPTH = 48,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Access
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [3:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [3:0] rdata_o
);
  logic [3:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_i && (int'(waddr_i) < DEPTH)) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_comb begin
    if (int'(raddr_i) < DEPTH) begin
      rdata_o = mem_reg[raddr_i];
    end else begin
      rdata_o = NIBBLE_ZERO;
    end
  end
endmodule

// ---- tb/cpu_core_model.sv ----
`timescale 1ns/10ps
module cpu_core_model
  import io_map_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Data memory request
  output mem_req_type req_o
);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  initial begin
    req_o = '0;
    req_o.addr = 12'h0fff;
  end

  // Plain nibble store, one cycle per write
  task automatic write_nib(input logic [11:0] addr, input logic [3:0] data);
    @(negedge clk_i);
    req_o.wr = 1'b1;
    req_o.addr = addr;
    req_o.wdata = data;
    @(negedge clk_i);
    req_o.wr = 1'b0;
    req_o.addr = ~addr;
    req_o.wdata = ~data;
  endtask

  // Write then read the same word back to back
  task automatic write_read_nib(input logic [11:0] addr, input logic [3:0] data);
    @(negedge clk_i);
    req_o.wr = 1'b1;
    req_o.addr = addr;
    req_o.wdata = data;
    @(negedge clk_i);
    req_o.wr = 1'b0;
    req_o.rd = 1'b1;
    @(negedge clk_i);
    req_o.rd = 1'b0;
    req_o.addr = ~addr;
    req_o.wdata = ~data;
  endtask

  // Caller picks the address, mapped or unmapped; t_unmapped reads unmapped addresses through it
  task automatic read_nib(input logic [11:0] addr);
    @(negedge clk_i);
    req_o.rd = 1'b1;
    req_o.addr = addr;
    @(negedge clk_i);
    req_o.rd = 1'b0;
    req_o.addr = ~addr;
  endtask
endmodule

// ---- tb/test_io_memory_map_decoder.sv ----
`timescale 1ns/10ps
module test_io_memory_map_decoder;
  import io_map_pkg::*;
  logic clk;
  logic reset_n;
  mem_req_type req;
  logic [3:0] taps, hund, tenth, pins, rdata0, rdata2, cmp0, irq0, drd0, drd2;
  logic sub_batt, hit0, hit2, lcd0, heavy0, sw1_0, sw10_0;
  logic [5:0] draddr;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  cpu_core_model i_cpu_core_model (.clk_i(clk), .req_o(req));

  io_memory_map_decoder #(.DISP_IN_PAGE2(1'b0)) i_io_memory_map_decoder (
    .CLK_I(clk), .RESET_N_I(reset_n), .MEM_RD_I(req.rd), .MEM_WR_I(req.wr),
    .MEM_ADDR_I(req.addr), .MEM_WDATA_I(req.wdata), .MEM_RDATA_O(rdata0), .MEM_HIT_O(hit0),
    .CLK_TAPS_I(taps), .SW_HUNDREDTHS_I(hund), .SW_TENTHS_I(tenth), .IN_PIN_I(pins),
    .SUB_BATTERY_DETECT_I(sub_batt), .LCD_BLANK_CTL_O(lcd0), .IN_CMP_O(cmp0), .IN_IRQ_EN_O(irq0),
    .HEAVY_LOAD_SEL_O(heavy0), .SWATCH_1HZ_IRQ_EN_O(sw1_0), .SWATCH_10HZ_IRQ_EN_O(sw10_0),
    .DISP_RADDR_I(draddr), .DISP_RDATA_O(drd0));

  io_memory_map_decoder #(.DISP_IN_PAGE2(1'b1)) i_io_memory_map_decoder_p2 (
    .CLK_I(clk), .RESET_N_I(reset_n), .MEM_RD_I(req.rd), .MEM_WR_I(req.wr),
    .MEM_ADDR_I(req.addr), .MEM_WDATA_I(req.wdata), .MEM_RDATA_O(rdata2), .MEM_HIT_O(hit2),
    .CLK_TAPS_I(taps), .SW_HUNDREDTHS_I(hund), .SW_TENTHS_I(tenth), .IN_PIN_I(pins),
    .SUB_BATTERY_DETECT_I(sub_batt), .LCD_BLANK_CTL_O(), .IN_CMP_O(), .IN_IRQ_EN_O(),
    .HEAVY_LOAD_SEL_O(), .SWATCH_1HZ_IRQ_EN_O(), .SWATCH_10HZ_IRQ_EN_O(),
    .DISP_RADDR_I(draddr), .DISP_RDATA_O(drd2));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read through both builds; e0 page 0 build, e2 page 2 build
  task automatic rd(input logic [11:0] a, input logic [3:0] e0, input logic [3:0] e2, input logic hit);
    rd_hits(a, e0, e2, hit, hit);
  endtask

  // Same, with a decode hit expected per build
  task automatic rd_hits(input logic [11:0] a, input logic [3:0] e0, input logic [3:0] e2,
                         input logic h0, input logic h2);
    i_cpu_core_model.read_nib(a);
    chk("rdata page0", e0, rdata0);
    chk("rdata page2", e2, rdata2);
    chk("hit page0", {3'h0, h0}, {3'h0, hit0});
    chk("hit page2", {3'h0, h2}, {3'h0, hit2});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("lcd blank", 4'h1, {3'h0, lcd0});
    rd(ADDR_LCD_BLANK, 4'h1, 4'h1, 1'b1);
    rd(ADDR_CLK_TAPS, 4'h0, 4'h0, 1'b1);
    rd(ADDR_IN_CMP, 4'h0, 4'h0, 1'b1);
    rd(ADDR_IN_IRQ_EN, 4'h0, 4'h0, 1'b1);
    rd(ADDR_LOAD_MODE, 4'h0, 4'h0, 1'b1);
  endtask

  task automatic t_ctrl();
    i_cpu_core_model.write_nib(ADDR_IN_CMP, 4'h5);
    chk("cmp out", 4'h5, cmp0);
    i_cpu_core_model.write_nib(ADDR_IN_CMP, 4'ha);
    rd(ADDR_IN_CMP, 4'ha, 4'ha, 1'b1);
    i_cpu_core_model.write_nib(ADDR_IN_IRQ_EN, 4'h3);
    chk("irq en out", 4'h3, irq0);
    rd(ADDR_IN_IRQ_EN, 4'h3, 4'h3, 1'b1);
    i_cpu_core_model.write_nib(ADDR_LOAD_MODE, 4'hf);
    chk("heavy", 4'h1, {3'h0, heavy0});
    chk("sw 1hz en", 4'h1, {3'h0, sw1_0});
    chk("sw 10hz en", 4'h1, {3'h0, sw10_0});
    rd(ADDR_LOAD_MODE, 4'hb, 4'hb, 1'b1);
    sub_batt = 1'b1;
    i_cpu_core_model.write_nib(ADDR_LOAD_MODE, 4'h2);
    repeat (3) @(negedge clk);
    rd(ADDR_LOAD_MODE, 4'h6, 4'h6, 1'b1);
    chk("heavy off", 4'h0, {3'h0, heavy0});
    i_cpu_core_model.write_nib(ADDR_LCD_BLANK, 4'he);
    chk("lcd blank", 4'h0, {3'h0, lcd0});
    rd(ADDR_LCD_BLANK, 4'h0, 4'h0, 1'b1);
  endtask

  task automatic t_ro();
    taps = 4'h9;
    hund = 4'h8;
    tenth = 4'h3;
    pins = 4'ha;
    repeat (4) @(negedge clk);
    rd(ADDR_CLK_TAPS, 4'h9, 4'h9, 1'b1);
    rd(ADDR_SW_HUND, 4'h8, 4'h8, 1'b1);
    rd(ADDR_SW_TENTH, 4'h3, 4'h3, 1'b1);
    i_cpu_core_model.write_nib(ADDR_IN_LEVELS, 4'h5);
    rd(ADDR_IN_LEVELS, 4'ha, 4'ha, 1'b1);
    i_cpu_core_model.write_nib(ADDR_IN_CMP, 4'h6);
    i_cpu_core_model.write_nib(ADDR_CLK_TAPS, 4'h0);
    rd(ADDR_IN_CMP, 4'h6, 4'h6, 1'b1);
  endtask

  task automatic t_disp();
    i_cpu_core_model.write_read_nib(12'h0040, 4'h7);
    chk("disp back to back page0", 4'h7, rdata0);
    chk("ram back to back page2", 4'h7, rdata2);
    i_cpu_core_model.write_nib(12'h006f, 4'hc);
    i_cpu_core_model.write_nib(12'h0240, 4'h6);
    i_cpu_core_model.write_nib(12'h026f, 4'h3);
    rd(12'h0040, 4'h7, 4'h7, 1'b1);
    rd(12'h006f, 4'hc, 4'hc, 1'b1);
    rd_hits(12'h0240, 4'h0, 4'h0, 1'b0, 1'b1);
    rd_hits(12'h026f, 4'h0, 4'h0, 1'b0, 1'b1);
    draddr = 6'h00;
    repeat (2) @(negedge clk);
    chk("lcd side page0", 4'h7, drd0);
    chk("lcd side page2", 4'h6, drd2);
    draddr = 6'h2f;
    repeat (2) @(negedge clk);
    chk("lcd side page0", 4'hc, drd0);
    chk("lcd side page2", 4'h3, drd2);
  endtask

  task automatic t_unmapped();
    rd(12'h02d1, 4'h0, 4'h0, 1'b0);
    rd(12'h02e7, 4'h0, 4'h0, 1'b0);
    rd(12'h0fff, 4'h0, 4'h0, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    taps = 4'h0;
    hund = 4'h0;
    tenth = 4'h0;
    pins = 4'h0;
    sub_batt = 1'b0;
    draddr = 6'h00;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_ctrl();
    t_ro();
    t_disp();
    t_unmapped();
    summarize();
  end
endmodule
